// >>> tcc_core.sv
// Timer/counter core: 16-bit count, clock select and prescaler, four
// modes, compare channels, overflow flag and interrupt vector.
// Assumes all clock source inputs are levels synchronous to mclk and
// that software halts the counter before changing the configuration.
//
// Overview of operation
// - Count steps on every 1st, 2nd, 4th or 8th rising edge of the selected clock
// - Software write replaces count at once
// - Overflow raises an interrupt request
// - Clear zeroes count, prescaler and direction
// - Flags set only when counted, not loaded
// - Two or three compare channels share count
// - Each channel raises its own interrupt
// - Vector register names highest pending source other than channel 0
// - Four modes, clock synchronous to mclk
// - Running count is registered in mclk; reads are whole, no majority vote
// - Mode field: stop, up, continuous, up/down
// - Continuous mode wraps FFFF to zero
// - Four sources, divide by 1,2,4,8
// - Advance only with nonzero mode, running clock
`timescale 1ns/1ps
`default_nettype none

module tcc_core (
  // Clock and reset
  input  wire logic                                 mclk,
  input  wire logic                                 resetn,
  // Timer clock sources
  input  wire logic                                 external_timer_clock,
  input  wire logic                                 aux_clock,
  input  wire logic                                 sub_main_clock,
  input  wire logic                                 inverted_external_clock,
  // Configuration and count access
  input  wire tcc_pkg::tcc_cfg_t                    cfg,
  input  wire logic                                 count_clear_bit,
  input  wire tcc_pkg::tcc_wr_t                     count_wr,
  // Compare channels
  input  wire logic [tcc_pkg::NUM_CH-1:0][15:0]     cmp_value,
  input  wire logic [tcc_pkg::NUM_CH-1:0]           cmp_int_en,
  input  wire logic [tcc_pkg::NUM_CH-1:0]           cmp_flag_clr,
  // Overflow and vector
  input  wire logic                                 ovf_int_en,
  input  wire logic                                 ovf_flag_clr,
  input  wire logic                                 vector_read,
  // Status outputs
  output logic [15:0]                               count_value,
  output logic                                      count_dir_down,
  output logic                                      overflow_flag,
  output logic [tcc_pkg::NUM_CH-1:0]                cmp_flag,
  output logic                                      ovf_irq,
  output logic [tcc_pkg::NUM_CH-1:0]                cmp_irq,
  output logic [15:0]                               int_vector
);

  logic [15:0]               cnt_r;
  logic [15:0]               cnt_nxt;
  logic                      dir_r;
  logic                      dir_nxt;
  logic [2:0]                div_r;
  logic [2:0]                div_nxt;
  logic                      src_prev_r;
  logic                      ovf_r;
  logic                      ovf_nxt;
  logic [tcc_pkg::NUM_CH-1:0] ccf_r;
  logic [tcc_pkg::NUM_CH-1:0] ccf_nxt;
  logic                      ovf_irq_r;
  logic [tcc_pkg::NUM_CH-1:0] cc_irq_r;
  logic [15:0]               vec_r;
  logic [15:0]               vec_nxt;

  // Clock source selection and edge detection
  wire tcc_pkg::tcc_mode_t mode = cfg.count_mode_field;
  wire logic src_sel =
    (cfg.clock_source_field == tcc_pkg::TCC_SRC_EXT) ? external_timer_clock :
    (cfg.clock_source_field == tcc_pkg::TCC_SRC_AUX) ? aux_clock :
    (cfg.clock_source_field == tcc_pkg::TCC_SRC_SUB) ? sub_main_clock :
                                                       inverted_external_clock;
  // A source switch while running can look like an edge; halt first
  wire logic src_rise = src_sel & ~src_prev_r;

  // Prescaler: divide rising edges by 1, 2, 4 or 8
  wire logic [2:0] div_mask = 3'((4'h1 << cfg.prescale_field) - 4'h1);
  wire logic       div_done = ((div_r & div_mask) == div_mask);

  // Up and up/down modes halt while the period is zero
  wire logic [15:0] period   = cmp_value[0];
  wire logic period_ok       = (period != tcc_pkg::CNT_ZERO) ||
                               (mode == tcc_pkg::TCC_MODE_CONT);
  wire logic running         = (mode != tcc_pkg::TCC_MODE_STOP) && period_ok;
  wire logic tick            = running && src_rise && div_done;
  wire logic at_period       = (cnt_r >= period);

  // Counter and direction next-state per mode
  logic        step_ovf;
  always_comb begin
    cnt_nxt  = cnt_r;
    dir_nxt  = dir_r;
    step_ovf = 1'b0;
    case (mode)
      tcc_pkg::TCC_MODE_CONT: begin
        cnt_nxt  = 16'(cnt_r + tcc_pkg::CNT_ONE);
        step_ovf = (cnt_r == tcc_pkg::CNT_MAX);
      end
      tcc_pkg::TCC_MODE_UP: begin
        if (at_period) begin
          cnt_nxt  = tcc_pkg::CNT_ZERO;
          step_ovf = (cnt_r == period);
        end else begin
          cnt_nxt = 16'(cnt_r + tcc_pkg::CNT_ONE);
        end
      end
      tcc_pkg::TCC_MODE_UPDN: begin
        // Direction is latched so a stopped timer resumes the same way
        if (!dir_r) begin
          if (at_period) begin
            dir_nxt = 1'b1;
            cnt_nxt = 16'(cnt_r - tcc_pkg::CNT_ONE);
          end else begin
            cnt_nxt = 16'(cnt_r + tcc_pkg::CNT_ONE);
          end
        end else if (cnt_r == tcc_pkg::CNT_ZERO) begin
          dir_nxt = 1'b0;
          cnt_nxt = tcc_pkg::CNT_ONE;
        end else begin
          cnt_nxt  = 16'(cnt_r - tcc_pkg::CNT_ONE);
          step_ovf = (cnt_r == tcc_pkg::CNT_ONE);
          dir_nxt  = (cnt_r != tcc_pkg::CNT_ONE);
        end
      end
      default: begin
        cnt_nxt = cnt_r;
      end
    endcase
  end

  // Count flags only on counting ticks; a software load sets nothing
  wire logic counted = tick && !count_clear_bit && !count_wr.wr;
  wire logic ovf_set = counted && step_ovf;

  // Compare channels, all referenced to the shared count
  logic [tcc_pkg::NUM_CH-1:0] cc_set;
  genvar gi;
  generate
    for (gi = 0; gi < tcc_pkg::NUM_CH; gi++) begin : g_ch
      assign cc_set[gi] = counted && (cnt_nxt == cmp_value[gi]) &&
                          (cnt_nxt != cnt_r);
    end
  endgenerate

  // Reading the vector services the source it names
  wire logic svc_ovf = vector_read && (vec_r == tcc_pkg::VEC_OVF);
  logic [tcc_pkg::NUM_CH-1:0] svc_cc;
  generate
    for (gi = 0; gi < tcc_pkg::NUM_CH; gi++) begin : g_svc
      assign svc_cc[gi] = vector_read && (gi != 0) &&
                          (vec_r == 16'(gi * tcc_pkg::VEC_STEP));
    end
  endgenerate

  // Hardware set wins over any clear arriving in the same cycle
  assign ovf_nxt = ovf_set | (ovf_r & ~(ovf_flag_clr | svc_ovf));
  assign ccf_nxt = cc_set | (ccf_r & ~(cmp_flag_clr | svc_cc));

  // Vector tracks the flags of the next cycle: highest channel down to 1 first, then
  // overflow; channel 0 has its own line and never appears here
  always_comb begin
    vec_nxt = tcc_pkg::VEC_NONE;
    for (int i = tcc_pkg::NUM_CH - 1; i >= 1; i--) begin
      if (ccf_nxt[i] && vec_nxt == tcc_pkg::VEC_NONE) begin
        vec_nxt = 16'(i * tcc_pkg::VEC_STEP);
      end
    end
    if (vec_nxt == tcc_pkg::VEC_NONE && ovf_nxt) begin
      vec_nxt = tcc_pkg::VEC_OVF;
    end
  end

  // Prescaler state
  always_comb begin
    div_nxt = div_r;
    if (count_clear_bit) begin
      div_nxt = tcc_pkg::DIV_ZERO;
    end else if (running && src_rise) begin
      div_nxt = div_done ? tcc_pkg::DIV_ZERO : 3'(div_r + tcc_pkg::DIV_ONE);
    end
  end

  // Count register: clear beats write, write beats counting
  logic [15:0] cnt_sel;
  logic        dir_sel;
  always_comb begin
    cnt_sel = cnt_r;
    dir_sel = dir_r;
    if (count_clear_bit) begin
      cnt_sel = tcc_pkg::CNT_ZERO;
      dir_sel = 1'b0;
    end else if (count_wr.wr) begin
      cnt_sel = count_wr.data;
    end else if (tick) begin
      cnt_sel = cnt_nxt;
      dir_sel = dir_nxt;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cnt_r      <= tcc_pkg::CNT_ZERO;
      dir_r      <= 1'b0;
      div_r      <= tcc_pkg::DIV_ZERO;
      src_prev_r <= 1'b0;
    end else begin
      cnt_r      <= cnt_sel;
      dir_r      <= dir_sel;
      div_r      <= div_nxt;
      src_prev_r <= src_sel;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ovf_r     <= 1'b0;
      ccf_r     <= '0;
      ovf_irq_r <= 1'b0;
      cc_irq_r  <= '0;
      vec_r     <= tcc_pkg::VEC_NONE;
    end else begin
      ovf_r     <= ovf_nxt;
      ccf_r     <= ccf_nxt;
      ovf_irq_r <= ovf_nxt & ovf_int_en;
      cc_irq_r  <= ccf_nxt & cmp_int_en;
      vec_r     <= vec_nxt;
    end
  end

  // Count is sampled in the mclk domain, so reads here are always whole;
  // software driving an asynchronous source needs no vote on running reads
  assign count_value    = cnt_r;
  assign count_dir_down = dir_r;
  assign overflow_flag  = ovf_r;
  assign cmp_flag       = ccf_r;
  assign ovf_irq        = ovf_irq_r;
  assign cmp_irq        = cc_irq_r;
  assign int_vector     = vec_r;

endmodule : tcc_core

`default_nettype wire

// >>> tcc_core_chk.sv
// Checker for tcc_core: count, clear, write, overflow flag and vector relations.
// Assumes one mclk domain with active-low async resetn; bound from the testbench.
`timescale 1ns/1ps
`default_nettype none

module tcc_core_chk (
  // Clock, reset and controls
  input wire logic                       mclk,
  input wire logic                       resetn,
  input wire tcc_pkg::tcc_cfg_t          cfg,
  input wire logic                       count_clear_bit,
  input wire tcc_pkg::tcc_wr_t           count_wr,
  input wire logic                       ovf_int_en,
  input wire logic                       ovf_flag_clr,
  input wire logic                       vector_read,
  // Observed outputs
  input wire logic [15:0]                count_value,
  input wire logic                       count_dir_down,
  input wire logic                       overflow_flag,
  input wire logic [tcc_pkg::NUM_CH-1:0] cmp_flag,
  input wire logic                       ovf_irq,
  input wire logic [15:0]                int_vector
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  // Software access of either kind replaces a tick
  wire logic sw = count_clear_bit | count_wr.wr;

  property p_clr; count_clear_bit |=> count_value == 16'h0000 && !count_dir_down; endproperty
  a_clr: assert property (p_clr) else $error("clear left count or direction");
  property p_wr; count_wr.wr && !count_clear_bit |=> count_value == $past(count_wr.data);
  endproperty
  a_wr: assert property (p_wr) else $error("write not taken at once");
  property p_stop;
    cfg.count_mode_field == tcc_pkg::TCC_MODE_STOP && !sw |=> $stable(count_value);
  endproperty
  a_stop: assert property (p_stop) else $error("count moved while halted");
  property p_step;
    $changed(count_value) && $past(cfg.count_mode_field == tcc_pkg::TCC_MODE_CONT && !sw)
      |-> count_value == $past(count_value) + 16'h0001;
  endproperty
  a_step: assert property (p_step) else $error("continuous step not plus one");
  property p_ovf; $rose(overflow_flag) |-> count_value == 16'h0000 && !$past(sw); endproperty
  a_ovf: assert property (p_ovf) else $error("overflow flag without counted wrap");
  property p_stick; overflow_flag && !ovf_flag_clr && !vector_read |=> overflow_flag;
  endproperty
  a_stick: assert property (p_stick) else $error("overflow flag dropped");
  property p_irq; $rose(overflow_flag) && ovf_int_en && $past(ovf_int_en) |-> ovf_irq;
  endproperty
  a_irq: assert property (p_irq) else $error("overflow request missing");
  property p_vec; overflow_flag && cmp_flag[2:1] == 2'h0 |-> int_vector == tcc_pkg::VEC_OVF;
  endproperty
  a_vec: assert property (p_vec) else $error("vector does not name overflow");

  c_ovf: cover property ($rose(overflow_flag));
  c_dir: cover property ($rose(count_dir_down));
  c_vec: cover property (vector_read && int_vector == tcc_pkg::VEC_STEP);
endmodule : tcc_core_chk

`default_nettype wire

// >>> tcc_core_test.sv
// Self-checking bench for tcc_core: drives clock sources, config and count access.
// Assumes the package and design are compiled first; the checker is bound below.
`timescale 1ns/1ps
`default_nettype none

module tcc_core_test;
  logic                             mclk, resetn, count_clear_bit, ovf_int_en, ovf_flag_clr;
  logic                             vector_read, count_dir_down, overflow_flag, ovf_irq;
  logic [3:0]                       src;
  tcc_pkg::tcc_cfg_t                cfg;
  tcc_pkg::tcc_wr_t                 count_wr;
  logic [tcc_pkg::NUM_CH-1:0][15:0] cmp_value;
  logic [tcc_pkg::NUM_CH-1:0]       cmp_int_en, cmp_flag_clr, cmp_flag, cmp_irq;
  logic [15:0]                      count_value, int_vector;
  int                               err_total, cmp_count, cyc;

  tcc_core DUT (.mclk, .resetn, .external_timer_clock(src[0]), .aux_clock(src[1]),
    .sub_main_clock(src[2]), .inverted_external_clock(src[3]), .cfg, .count_clear_bit,
    .count_wr, .cmp_value, .cmp_int_en, .cmp_flag_clr, .ovf_int_en, .ovf_flag_clr,
    .vector_read, .count_value, .count_dir_down, .overflow_flag, .cmp_flag, .ovf_irq,
    .cmp_irq, .int_vector);

  task automatic chk(string n, logic [15:0] s, logic [15:0] e);
    cmp_count++;
    if (s !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  // Source high one cycle then low one cycle, so rises never merge
  task automatic tick(int s);
    @(posedge mclk) src[s] <= 1'b1;
    @(posedge mclk) src[s] <= 1'b0;
    #1;
  endtask : tick

  // Bits: clear, vector read, overflow clear, channel clears
  task automatic pulse(logic [5:0] v);
    @(posedge mclk) {count_clear_bit, vector_read, ovf_flag_clr, cmp_flag_clr} <= v;
    @(posedge mclk) {count_clear_bit, vector_read, ovf_flag_clr, cmp_flag_clr} <= 6'h00;
    #1;
  endtask : pulse

  task automatic wr(logic [15:0] d);
    @(posedge mclk) count_wr <= {1'b1, d};
    @(posedge mclk) count_wr.wr <= 1'b0;
    #1;
  endtask : wr

  // Halt for one cycle before any reconfiguration
  task automatic setc(tcc_pkg::tcc_mode_t m, int s, int p);
    @(posedge mclk) cfg.count_mode_field <= tcc_pkg::TCC_MODE_STOP;
    @(posedge mclk) cfg <= {m, 2'(s), 2'(p)};
    #1;
  endtask : setc

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : finish_test

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  // Whole run needs well under 2000 cycles
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_total++;
      finish_test();
    end
  end

  initial begin
    resetn = 1'b0;
    src = 4'h0;
    cfg = '0;
    count_wr = '0;
    {count_clear_bit, vector_read, ovf_flag_clr, cmp_flag_clr} = 6'h00;
    ovf_int_en = 1'b1;
    cmp_int_en = '1;
    cmp_value = {16'h0100, 16'h0002, 16'h0003};
    err_total = 0;
    cmp_count = 0;
    cyc = 0;
    repeat (3) @(posedge mclk);
    resetn <= 1'b1;
    for (int s = 0; s < 4; s++) begin
      for (int p = 0; p < 4; p++) begin
        setc(tcc_pkg::TCC_MODE_CONT, s, p);
        // Leaves the prescaler part-way, or at divide by 1 steps the count, so the clear must reset it
        tick(s);
        pulse(6'h20);
        repeat (2 << p) tick(s);
        tick((s + 1) % 4);
        chk("divided count", count_value, 16'h0002);
      end
    end
    setc(tcc_pkg::TCC_MODE_STOP, 0, 0);
    tick(0);
    chk("halted count", count_value, 16'h0002);
    $display("test sources, dividers and halt done");
    pulse(6'h0F);
    setc(tcc_pkg::TCC_MODE_CONT, 0, 0);
    wr(16'hFFFF);
    chk("written count", count_value, 16'hFFFF);
    chk("flag after write", overflow_flag, 1'b0);
    tick(0);
    chk("wrapped count", count_value, 16'h0000);
    chk("overflow vector", int_vector, tcc_pkg::VEC_OVF);
    chk("overflow request", ovf_irq, 1'b1);
    tick(0);
    chk("held flag", overflow_flag, 1'b1);
    pulse(6'h10);
    chk("serviced flag", overflow_flag, 1'b0);
    wr(16'h0000);
    chk("flag after zero load", overflow_flag, 1'b0);
    $display("test continuous overflow done");
    setc(tcc_pkg::TCC_MODE_UP, 0, 0);
    @(posedge mclk) ovf_int_en <= 1'b0;
    pulse(6'h2F);
    repeat (2) tick(0);
    chk("channel request", cmp_irq, 3'b010);
    chk("channel vector", int_vector, tcc_pkg::VEC_STEP);
    repeat (2) tick(0);
    chk("period wrap", count_value, 16'h0000);
    chk("channel flags", cmp_flag, 3'b011);
    chk("masked flag", overflow_flag, 1'b1);
    chk("masked request", ovf_irq, 1'b0);
    pulse(6'h10);
    chk("next vector", int_vector, tcc_pkg::VEC_OVF);
    $display("test up mode done");
    setc(tcc_pkg::TCC_MODE_UPDN, 0, 0);
    pulse(6'h20);
    repeat (4) tick(0);
    chk("descending count", count_value, 16'h0002);
    chk("down direction", count_dir_down, 1'b1);
    pulse(6'h20);
    chk("direction cleared", count_dir_down, 1'b0);
    chk("count cleared", count_value, 16'h0000);
    $display("test up/down mode done");
    finish_test();
  end
endmodule : tcc_core_test

bind tcc_core tcc_core_chk u_chk (.mclk, .resetn, .cfg, .count_clear_bit, .count_wr,
  .ovf_int_en, .ovf_flag_clr, .vector_read, .count_value, .count_dir_down, .overflow_flag,
  .cmp_flag, .ovf_irq, .int_vector);

`default_nettype wire

// >>> tcc_pkg.sv
// Shared constants and carrier types for the timer/counter core.
// Assumes a single system clock; no bus is present, so the fields are ports.
package tcc_pkg;

  localparam int CNT_W  = 16;
  localparam int NUM_CH = 3;   // Set to 2 for the smaller variant

  localparam logic [15:0] CNT_ZERO = 16'h0000;
  localparam logic [15:0] CNT_ONE  = 16'h0001;
  localparam logic [15:0] CNT_MAX  = 16'hFFFF;
  localparam logic [2:0]  DIV_ZERO = 3'h0;
  localparam logic [2:0]  DIV_ONE  = 3'h1;

  // Vector codes, highest channel code has highest priority, overflow lowest; 0 means nothing pending
  localparam logic [15:0] VEC_NONE = 16'h0000;
  localparam logic [15:0] VEC_STEP = 16'h0002;
  localparam logic [15:0] VEC_OVF  = 16'h000A;

  typedef enum logic [1:0] {
    TCC_MODE_STOP = 2'b00,
    TCC_MODE_UP   = 2'b01,
    TCC_MODE_CONT = 2'b10,
    TCC_MODE_UPDN = 2'b11
  } tcc_mode_t;

  typedef enum logic [1:0] {
    TCC_SRC_EXT  = 2'b00,
    TCC_SRC_AUX  = 2'b01,
    TCC_SRC_SUB  = 2'b10,
    TCC_SRC_INV  = 2'b11
  } tcc_src_t;

  // Static configuration, changed only while halted
  typedef struct packed {
    tcc_mode_t  count_mode_field;
    tcc_src_t   clock_source_field;
    logic [1:0] prescale_field;
  } tcc_cfg_t;

  // Software count write
  typedef struct packed {
    logic             wr;
    logic [CNT_W-1:0] data;
  } tcc_wr_t;

endpackage : tcc_pkg
